/* shared/flash_pe_pkg.sv */
package flash_pe_pkg;

    // ==========================================================
    // Register map (byte offsets on the bus)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PROT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // ==========================================================
    // Status register bit positions
    localparam int STAT_ARMED = 0;
    localparam int STAT_BLOCKED = 1;
    localparam int STAT_MASS_OFF = 2;
    localparam int STAT_HV = 3;
    localparam int STAT_ACTIVE = 4;
    localparam int STAT_TEST_HV = 5;

    // ==========================================================
    // Array address map
    localparam logic [15:0] ARRAY_LO = 16'hEE00;
    localparam logic [15:0] ARRAY_HI = 16'hFDFF;
    localparam logic [15:0] VEC_LO = 16'hFFD0;
    localparam logic [15:0] PROT_ADDR = 16'hFFBE;
    localparam int PAGE_LSB = 6;
    localparam int ROW_LSB = 5;

    // ==========================================================
    // Protect start register
    localparam logic [7:0] PROT_OPEN = 8'hFF;
    localparam logic [7:0] PROT_RESET = 8'hFF;
    localparam logic [1:0] PROT_TOP = 2'h3;
    localparam logic [5:0] PROT_LOW = 6'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic hvEnable;
        logic bulkErase;
        logic eraseSel;
        logic progSel;
    } ctrl_t;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } arr_wr_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SELECTED,
        SEQ_PROT_READ,
        SEQ_ARMED,
        SEQ_ACTIVE
    } seq_t;

endpackage

/* rtl/flash_program_erase_control.sv */
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// RULE_01: Array 4096 bytes plus 48-byte vector area
// RULE_02: Erase 64 bytes, program 32; erased reads one
// RULE_03: High voltage sets only after proper sequence
// RULE_04: Bulk-erase bit widens erase to whole array
// RULE_05: Erase and program selects never both one
// RULE_06: Erase page is 64 aligned bytes
// RULE_07: Page erase: select, read protect, write page
// RULE_08: Page erase waits and clear order by software
// RULE_09: Prefer 4 ms erase for endurance
// RULE_10: Mass erase sequence and waits by software
// RULE_11: Mass erase off unless protect is all ones
// RULE_12: Secured monitor mass setup writes protect register
// RULE_13: Program row is 32 aligned bytes
// RULE_14: Program only bytes that read all ones
// RULE_15: Program select latches address and data
// RULE_16: Row end: clear select, wait, clear voltage
// RULE_17: Keep byte intervals below maximum program time
// RULE_18: No watchdog write while high voltage on
// RULE_19: Steps run from outside array, in order
// RULE_20: Protected range refuses high voltage
// RULE_21: Protect zero locks all, ones opens all
// RULE_22: Protected block locked unless test voltage
// RULE_23: Protect bits form start address bits 13..6
// RULE_24: Wait or stop aborts to standby
// RULE_25: Array writes without select do nothing
// RULE_26: Control register clears on reset
module flash_program_erase_control (
    input wire logic clk, // 20 MHz system clock
    input wire logic resetn, // Asynchronous reset
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [31:0] dat_i, // Wishbone write data
    input wire logic [3:0] sel_i, // Wishbone byte selects
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire flash_pe_pkg::arr_wr_t arrayWr, // CPU write into array space
    input wire logic testHighVoltage, // Test voltage seen on interrupt pin
    input wire logic lowPowerEntry, // Wait or stop being entered
    output logic highVoltageOut, // Charge pump and array voltage
    output flash_pe_pkg::ctrl_t arrayMode, // Control bits to the array
    output logic [15:0] latchedAddr, // Latched target address
    output logic byteProgPulse, // Program one latched byte
    output logic [15:0] progAddr, // Address of byte to program
    output logic [7:0] progData, // Data of byte to program
    output logic [7:0] protectStartBits // Current protect value
);
    import flash_pe_pkg::*;

    // ==========================================================
    // State
    ctrl_t ctrl_reg;
    ctrl_t ctrl_next;
    seq_t seq_reg;
    seq_t seq_next;
    logic [7:0] protectStart_reg;
    logic [7:0] protectStart_next;
    logic [15:0] target_reg;
    logic pulse_reg;
    logic [15:0] progAddr_reg;
    logic [7:0] progData_reg;
    logic ack_reg;
    logic [31:0] rdData_reg;
    logic tstMeta_reg;
    logic tstSync_reg;

    // ==========================================================
    // Bus decode
    wire busReq = cyc_i & stb_i;
    wire busFire = busReq & ack_reg;
    wire wrFire = busFire & we_i & sel_i[0];
    wire rdFire = busFire & ~we_i;
    wire hitCtrl = adr_i == CTRL_OFS;
    wire hitProt = adr_i == PROT_OFS;
    wire hitStat = adr_i == STAT_OFS;
    wire ctrl_t req = ctrl_t'(dat_i[3:0]);

    // ==========================================================
    // Protection
    // RULE_23: start address build
    wire [15:0] protStartAddr = {PROT_TOP, protectStart_reg, PROT_LOW};
    wire protOpen = protectStart_reg == PROT_OPEN;
    // RULE_20: protected range check
    // RULE_21: zero locks everything, ones none
    // RULE_22: test voltage lifts the lock
    wire targetBlocked = ~protOpen & ~tstSync_reg & (target_reg >= protStartAddr);
    // RULE_11: mass erase disable
    // RULE_04: bulk select needs open array
    wire massBlocked = ctrl_reg.bulkErase & ~protOpen;

    // ==========================================================
    // Array space decode
    wire [15:0] wa = arrayWr.addr;
    // RULE_01: user array and vector area
    wire inArray = (wa >= ARRAY_LO && wa <= ARRAY_HI) || wa >= VEC_LO || wa == PROT_ADDR;
    wire arrWrite = arrayWr.we & inArray;
    // RULE_13: write must stay in the latched row
    wire sameRow = wa[15:ROW_LSB] == target_reg[15:ROW_LSB];
    wire anySel = ctrl_reg.eraseSel | ctrl_reg.progSel;
    wire hvAllowed = seq_reg == SEQ_ARMED && anySel && !targetBlocked && !massBlocked;
    wire selChange = {ctrl_next.eraseSel, ctrl_next.progSel} != {ctrl_reg.eraseSel, ctrl_reg.progSel};
    wire eraseStart = seq_reg == SEQ_ARMED && seq_next == SEQ_ACTIVE && ctrl_reg.eraseSel;
    // RULE_06: page holding the protect byte
    wire protPageHit = target_reg[15:PAGE_LSB] == PROT_ADDR[15:PAGE_LSB];
    // RULE_15: byte latched during active program
    // RULE_25: no select, no effect
    wire pulseNext = seq_reg == SEQ_ACTIVE && ctrl_reg.progSel && ctrl_reg.hvEnable
        && arrWrite && sameRow && !lowPowerEntry;

    // ==========================================================
    // Control register next value
    always_comb begin
        ctrl_next = ctrl_reg;
        // RULE_24: abort to standby
        if (lowPowerEntry) begin
            ctrl_next = ctrl_t'(CTRL_RESET);
        end else if (wrFire && hitCtrl) begin
            ctrl_next.bulkErase = req.bulkErase;
            // RULE_05: refuse both selects at once
            if (!(req.eraseSel && req.progSel)) begin
                ctrl_next.eraseSel = req.eraseSel;
                ctrl_next.progSel = req.progSel;
            end
            // RULE_03: high voltage gating
            if (!req.hvEnable) begin
                ctrl_next.hvEnable = 1'b0;
            end else if (!ctrl_reg.hvEnable && hvAllowed && !selChange) begin
                ctrl_next.hvEnable = 1'b1;
            end
        end
    end

    // ==========================================================
    // Sequence tracking
    // RULE_07: select, protect read, setup write
    always_comb begin
        seq_next = seq_reg;
        if (lowPowerEntry || !(ctrl_next.eraseSel || ctrl_next.progSel)) begin
            seq_next = SEQ_IDLE;
        end else if (selChange) begin
            seq_next = SEQ_SELECTED;
        end else begin
            unique case (seq_reg)
                SEQ_IDLE: begin
                    seq_next = SEQ_SELECTED;
                end
                SEQ_SELECTED: begin
                    if (rdFire && hitProt) begin
                        seq_next = SEQ_PROT_READ;
                    end
                end
                SEQ_PROT_READ: begin
                    if (arrWrite) begin
                        seq_next = SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    if (ctrl_next.hvEnable) begin
                        seq_next = SEQ_ACTIVE;
                    end
                end
                SEQ_ACTIVE: begin
                    seq_next = SEQ_ACTIVE;
                end
            endcase
        end
    end

    // ==========================================================
    // Protect byte kept in the array
    always_comb begin
        protectStart_next = protectStart_reg;
        // RULE_02: programming only clears bits
        if (pulse_reg && progAddr_reg == PROT_ADDR) begin
            protectStart_next = protectStart_reg & progData_reg;
        end else if (eraseStart && (ctrl_reg.bulkErase || protPageHit)) begin
            protectStart_next = PROT_OPEN;
        end
    end

    // ==========================================================
    // Registers
    // RULE_26: reset clears control
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= ctrl_t'(CTRL_RESET);
            seq_reg <= SEQ_IDLE;
            protectStart_reg <= PROT_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            seq_reg <= seq_next;
            protectStart_reg <= protectStart_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            target_reg <= 16'h0000;
        end else if (seq_reg == SEQ_PROT_READ && seq_next == SEQ_ARMED) begin
            target_reg <= wa;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_reg <= 1'b0;
            progAddr_reg <= 16'h0000;
            progData_reg <= 8'h00;
        end else begin
            pulse_reg <= pulseNext;
            if (pulseNext) begin
                progAddr_reg <= wa;
                progData_reg <= arrayWr.data;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tstMeta_reg <= 1'b0;
            tstSync_reg <= 1'b0;
        end else begin
            tstMeta_reg <= testHighVoltage;
            tstSync_reg <= tstMeta_reg;
        end
    end

    // ==========================================================
    // Bus slave
    wire [31:0] statWord = {26'h000_0000, tstSync_reg, seq_reg == SEQ_ACTIVE, ctrl_reg.hvEnable,
        ~protOpen, targetBlocked, seq_reg == SEQ_ARMED};
    wire [31:0] rdMux = hitCtrl ? {28'h000_0000, ctrl_reg}
        : hitProt ? {24'h00_0000, protectStart_reg}
        : hitStat ? statWord : 32'h0000_0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            rdData_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= busReq & ~ack_reg;
            if (busReq && !ack_reg) begin
                rdData_reg <= rdMux;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign dat_o = rdData_reg;
    assign ack_o = ack_reg;
    assign highVoltageOut = ctrl_reg.hvEnable;
    assign arrayMode = ctrl_reg;
    assign latchedAddr = target_reg;
    assign byteProgPulse = pulse_reg;
    assign progAddr = progAddr_reg;
    assign progData = progData_reg;
    assign protectStartBits = protectStart_reg;

    // ==========================================================
    // Checks
    a_sel_interlock: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
        !(ctrl_reg.eraseSel && ctrl_reg.progSel))
        else $error("erase and program selects both set");

    a_hv_after_arm: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
        $rose(ctrl_reg.hvEnable) |-> $past(seq_reg) == SEQ_ARMED && seq_reg == SEQ_ACTIVE)
        else $error("high voltage set outside armed step");

    a_hv_protect_gate: assert property (@(posedge clk) disable iff (!resetn) // RULE_20
        $rose(ctrl_reg.hvEnable) |-> !$past(targetBlocked))
        else $error("high voltage set on protected target");

    a_mass_gate: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
        $rose(ctrl_reg.hvEnable) && ctrl_reg.bulkErase |-> $past(protectStart_reg) == PROT_OPEN)
        else $error("mass erase started while protected");

    a_lowpower_abort: assert property (@(posedge clk) disable iff (!resetn) // RULE_24
        lowPowerEntry |=> ctrl_reg == ctrl_t'(CTRL_RESET) && seq_reg == SEQ_IDLE && !byteProgPulse)
        else $error("wait or stop did not abort");

    a_prog_row: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
        byteProgPulse |-> progAddr[15:ROW_LSB] == target_reg[15:ROW_LSB] && $past(ctrl_reg.hvEnable))
        else $error("program byte outside latched row");

    a_idle_write: assert property (@(posedge clk) disable iff (!resetn) // RULE_25
        arrayWr.we && !ctrl_reg.eraseSel && !ctrl_reg.progSel |=> !byteProgPulse)
        else $error("array write without select had effect");

    a_protect_lock: assert property (@(posedge clk) disable iff (!resetn) // RULE_22
        !protOpen && !tstSync_reg && !ctrl_reg.hvEnable ##1 !pulse_reg
        |-> $stable(protectStart_reg))
        else $error("locked protect value changed");

    a_ack_pulse: assert property (@(posedge clk) disable iff (!resetn)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus acknowledge not a single cycle");

endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import flash_pe_pkg::*;
    // ==========================================================
    // Signals
    logic clk;
    logic resetn;
    logic cycI;
    logic stbI;
    logic weI;
    logic [7:0] adrI;
    logic [31:0] datI;
    logic [3:0] selI;
    logic [31:0] datO;
    logic ackO;
    arr_wr_t arrayWrIn;
    logic testHv;
    logic lowPower;
    logic hvOut;
    ctrl_t arrayMode;
    logic [15:0] latchedAddr;
    logic byteProgPulse;
    logic [15:0] progAddr;
    logic [7:0] progData;
    logic [7:0] protectStartBits;
    logic [31:0] rdData;
    logic [7:0] rowData [7];
    logic [3:0] rowExp [7];
    int num_errors;
    int check_count;
    int cycles;

    flash_program_erase_control flash_program_erase_control_inst (
        .clk(clk), .resetn(resetn), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
        .dat_i(datI), .sel_i(selI), .dat_o(datO), .ack_o(ackO), .arrayWr(arrayWrIn),
        .testHighVoltage(testHv), .lowPowerEntry(lowPower), .highVoltageOut(hvOut),
        .arrayMode(arrayMode), .latchedAddr(latchedAddr), .byteProgPulse(byteProgPulse),
        .progAddr(progAddr), .progData(progData), .protectStartBits(protectStartBits)
    );

    // ==========================================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ==========================================================
    // Tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
        check_count++;
        if (got !== expv) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, expv, got);
        end
    endtask

    task automatic wbCycle(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cycI <= 1'b1;
        stbI <= 1'b1;
        weI <= w;
        adrI <= a;
        selI <= 4'h1;
        datI <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (ackO !== 1'b1);
        rdData = datO;
        cycI <= 1'b0;
        stbI <= 1'b0;
        weI <= 1'b0;
    endtask

    task automatic setCtrl(input logic [7:0] d, input logic [3:0] expv);
        wbCycle(CTRL_OFS, 1'b1, d);
        #1;
        chk("control", {28'h000_0000, expv}, {28'h000_0000, arrayMode});
        chk("highVoltage", {31'h0000_0000, expv[3]}, {31'h0000_0000, hvOut});
    endtask

    task automatic arrWrite(input logic [15:0] a, input logic [7:0] d, input logic expPulse);
        @(posedge clk);
        arrayWrIn <= '{we: 1'b1, addr: a, data: d};
        @(posedge clk);
        arrayWrIn.we <= 1'b0;
        #1;
        chk("pulse", {31'h0000_0000, expPulse}, {31'h0000_0000, byteProgPulse});
        if (expPulse) begin
            chk("progAddr", {16'h0000, a}, {16'h0000, progAddr});
            chk("progData", {24'h00_0000, d}, {24'h00_0000, progData});
        end
    endtask

    task automatic setup(input logic [3:0] bits, input logic [15:0] a);
        setCtrl({4'h0, bits}, bits);
        wbCycle(PROT_OFS, 1'b0, 8'h00);
        arrWrite(a, 8'h00, 1'b0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        {cycI, stbI, weI, testHv, lowPower} = '0;
        adrI = 8'h00;
        datI = 32'h0000_0000;
        selI = 4'h1;
        arrayWrIn = '0;
        rowData = '{8'h03, 8'h08, 8'h02, 8'h03, 8'h06, 8'h01, 8'h00};
        rowExp = '{4'h0, 4'h0, 4'h2, 4'h2, 4'h6, 4'h1, 4'h0};
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("control", 32'h0000_0000, {28'h000_0000, arrayMode});
        chk("protect", 32'h0000_00FF, {24'h00_0000, protectStartBits});
        wbCycle(CTRL_OFS, 1'b0, 8'h00);
        chk("ctrlRead", 32'h0000_0000, rdData);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            setCtrl(rowData[i], rowExp[i]);
        end
        $display("test control table done");
        setup(4'h1, 16'hEE20);
        chk("latchedAddr", 32'h0000_EE20, {16'h0000, latchedAddr});
        setCtrl(8'h09, 4'h9);
        wbCycle(STAT_OFS, 1'b0, 8'h00);
        chk("status", 32'h0000_0018, rdData);
        arrWrite(16'hEE21, 8'h5A, 1'b1);
        arrWrite(16'hEE3F, 8'hC3, 1'b1);
        arrWrite(16'hEE40, 8'h33, 1'b0);
        setCtrl(8'h08, 4'h8);
        setCtrl(8'h00, 4'h0);
        arrWrite(16'hEE00, 8'h00, 1'b0);
        $display("test program row done");
        setCtrl(8'h01, 4'h1);
        arrWrite(16'hEE00, 8'h00, 1'b0);
        setCtrl(8'h09, 4'h1);
        setCtrl(8'h00, 4'h0);
        $display("test order fault done");
        setup(4'h1, PROT_ADDR);
        setCtrl(8'h09, 4'h9);
        arrWrite(PROT_ADDR, 8'hB9, 1'b1);
        setCtrl(8'h08, 4'h8);
        setCtrl(8'h00, 4'h0);
        chk("protect", 32'h0000_00B9, {24'h00_0000, protectStartBits});
        wbCycle(PROT_OFS, 1'b0, 8'h00);
        chk("protRead", 32'h0000_00B9, rdData);
        // Protect start now sits at EE40
        setup(4'h2, 16'hEE00);
        setCtrl(8'h0A, 4'hA);
        setCtrl(8'h08, 4'h8);
        setCtrl(8'h00, 4'h0);
        setup(4'h2, 16'hEE40);
        setCtrl(8'h0A, 4'h2);
        wbCycle(STAT_OFS, 1'b0, 8'h00);
        chk("status", 32'h0000_0007, rdData);
        setCtrl(8'h00, 4'h0);
        setup(4'h6, 16'hEE00);
        setCtrl(8'h0E, 4'h6);
        setCtrl(8'h00, 4'h0);
        $display("test protection done");
        testHv <= 1'b1;
        repeat (3) @(posedge clk);
        setup(4'h2, PROT_ADDR);
        setCtrl(8'h0A, 4'hA);
        wbCycle(STAT_OFS, 1'b0, 8'h00);
        chk("status", 32'h0000_0038, rdData);
        setCtrl(8'h08, 4'h8);
        setCtrl(8'h00, 4'h0);
        chk("protect", 32'h0000_00FF, {24'h00_0000, protectStartBits});
        testHv <= 1'b0;
        setup(4'h6, PROT_ADDR);
        setCtrl(8'h0E, 4'hE);
        @(posedge clk);
        lowPower <= 1'b1;
        @(posedge clk);
        lowPower <= 1'b0;
        #1;
        chk("control", 32'h0000_0000, {28'h000_0000, arrayMode});
        chk("highVoltage", 32'h0000_0000, {31'h0000_0000, hvOut});
        $display("test test voltage and abort done");
        wbCycle(8'h40, 1'b1, 8'hFF);
        wbCycle(8'h40, 1'b0, 8'h00);
        chk("unmapped", 32'h0000_0000, rdData);
        $display("test unmapped done");
        wrap_up();
    end
endmodule
